/* verilog/smc_config_pointer.sv */
// Summary of operation
// - bit 0 of the clock divisor is held at zero and only bits 7:1 accept writes.
// - an all-zero divisor field stops the serial scan clock entirely.
// - a single divisor bit divides the system clock by its weight, from 2 up to 128.
// - a 3-bit select picks no polynomial or one of three fixed 32-bit polynomials.
// - the 32-bit seed is built from a low and a high 16-bit register.
// - the 32-bit signature is shown as low and high 16-bit read/write registers.
// - a write to the shared pointer loads the scan out, scan in, expected and mask pointers.
// - scan in advances per long word read, the other three per long word written.
// - the vector pointer register sets the vector data pointer.
// - the header/trailer pointer register sets the header and trailer data pointer.
// - the macro pointer register sets the macro data pointer.
// - the sequencer pointer register sets the sequencer data pointer.
`timescale 1ns/1ps
`include "smc_regs.svh"

module smc_config_pointer
  import smc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic strobe_n,
  input wire logic read_not_write,
  input wire logic [4:0] addr,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe,
  output logic ack_n,
  output logic scan_clk,
  output logic scan_clk_tick,
  input wire logic scan_data_in,
  input wire logic scan_in_valid,
  input wire logic signature_start,
  input wire logic tdi_word_read,
  input wire logic tdo_word_write,
  input wire logic expected_word_write,
  input wire logic mask_word_write,
  output logic [15:0] scan_out_ptr,
  output logic [15:0] scan_in_ptr,
  output logic [15:0] expected_ptr,
  output logic [15:0] mask_ptr,
  output logic [15:0] vector_ptr,
  output logic [15:0] header_trailer_ptr,
  output logic [15:0] macro_ptr,
  output logic [15:0] sequencer_ptr,
  output logic [31:0] signature,
  output logic poly_active
);

  smc_bus_state_t bus_state;
  smc_bus_state_t next_bus_state;

  logic [6:0] divisor_field;
  logic [2:0] poly_select;
  logic [15:0] seed_low;
  logic [15:0] seed_high;
  logic [15:0] shared_data_pointer;
  logic [31:0] signature_register;
  logic [31:0] taps;
  logic [31:0] next_signature;
  logic feedback;
  logic [15:0] read_word;

  logic select;
  logic take;
  logic wr_take;
  logic rd_take;

  // one access is taken per strobe; the answer holds until the strobe drops
  assign select = !cs_n && !strobe_n;
  assign take = select && (bus_state == SMC_BUS_IDLE);
  assign wr_take = take && !read_not_write;
  assign rd_take = take && read_not_write;

  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      SMC_BUS_IDLE: begin
        if (select) begin
          next_bus_state = SMC_BUS_HOLD;
        end
      end
      SMC_BUS_HOLD: begin
        if (!select) begin
          next_bus_state = SMC_BUS_IDLE;
        end
      end
      default: begin
        next_bus_state = SMC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bus_state <= SMC_BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ack_n <= 1'b1;
    end else begin
      ack_n <= !(next_bus_state == SMC_BUS_HOLD);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      data_oe <= 1'b0;
    end else if (rd_take) begin
      data_oe <= 1'b1;
    end else if (!select) begin
      data_oe <= 1'b0;
    end
  end

  // read data is captured at the take so it stays stable while the strobe is low
  always_comb begin
    case (addr)
      `SMC_ADDR_DIVISOR: begin
        read_word = {8'h00, divisor_field, 1'b0};
      end
      `SMC_ADDR_POLY_SELECT: begin
        read_word = {13'h0000, poly_select};
      end
      `SMC_ADDR_SEED_LOW: begin
        read_word = seed_low;
      end
      `SMC_ADDR_SEED_HIGH: begin
        read_word = seed_high;
      end
      `SMC_ADDR_RESULT_LOW: begin
        read_word = signature_register[15:0];
      end
      `SMC_ADDR_RESULT_HIGH: begin
        read_word = signature_register[31:16];
      end
      `SMC_ADDR_SHARED_POINTER: begin
        read_word = shared_data_pointer;
      end
      `SMC_ADDR_VECTOR_POINTER: begin
        read_word = vector_ptr;
      end
      `SMC_ADDR_HT_POINTER: begin
        read_word = header_trailer_ptr;
      end
      `SMC_ADDR_MACRO_POINTER: begin
        read_word = macro_ptr;
      end
      `SMC_ADDR_SEQ_POINTER: begin
        read_word = sequencer_ptr;
      end
      default: begin
        read_word = `SMC_UNMAPPED_READ;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      data_out <= `SMC_WORD_RESET;
    end else if (rd_take) begin
      data_out <= read_word;
    end
  end

  // scan clock divisor
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      divisor_field <= `SMC_DIV_RESET;
    end else if (wr_take && addr == `SMC_ADDR_DIVISOR) begin
      divisor_field <= data_in[`SMC_DIV_MSB:`SMC_DIV_LSB];
    end
  end

  smc_clk_div u_clk_div (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .divisor({divisor_field, 1'b0}),
    .scan_clk(scan_clk),
    .scan_clk_tick(scan_clk_tick)
  );

  // signature polynomial select and seed
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      poly_select <= 3'h0;
    end else if (wr_take && addr == `SMC_ADDR_POLY_SELECT) begin
      poly_select <= data_in[`SMC_POLY_MSB:0];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      seed_low <= `SMC_WORD_RESET;
    end else if (wr_take && addr == `SMC_ADDR_SEED_LOW) begin
      seed_low <= data_in;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      seed_high <= `SMC_WORD_RESET;
    end else if (wr_take && addr == `SMC_ADDR_SEED_HIGH) begin
      seed_high <= data_in;
    end
  end

  // codes above three select nothing, like code zero
  always_comb begin
    case (smc_poly_t'(poly_select))
      SMC_POLY_ONE: begin
        taps = `SMC_POLY1_TAPS;
      end
      SMC_POLY_TWO: begin
        taps = `SMC_POLY2_TAPS;
      end
      SMC_POLY_THREE: begin
        taps = `SMC_POLY3_TAPS;
      end
      default: begin
        taps = `SMC_SIG_RESET;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      poly_active <= 1'b0;
    end else begin
      poly_active <= (taps != `SMC_SIG_RESET);
    end
  end

  // galois form: the input bit folds into the msb that leaves
  assign feedback = signature_register[31] ^ scan_data_in;

  always_comb begin
    next_signature = signature_register;
    if (signature_start) begin
      next_signature = {seed_high, seed_low};
    end else if (scan_in_valid && taps != `SMC_SIG_RESET) begin
      next_signature = {signature_register[30:0], 1'b0} ^ (feedback ? taps : 32'h00000000);
    end
  end

  // a processor write wins over the shift for the half it touches
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      signature_register <= `SMC_SIG_RESET;
    end else if (wr_take && addr == `SMC_ADDR_RESULT_LOW) begin
      signature_register <= {next_signature[31:16], data_in};
    end else if (wr_take && addr == `SMC_ADDR_RESULT_HIGH) begin
      signature_register <= {data_in, next_signature[15:0]};
    end else begin
      signature_register <= next_signature;
    end
  end

  assign signature = signature_register;

  // shared pointer register and the four pointers it seeds
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      shared_data_pointer <= `SMC_WORD_RESET;
    end else if (wr_take && addr == `SMC_ADDR_SHARED_POINTER) begin
      shared_data_pointer <= data_in;
    end
  end

  // a load in the same cycle as an advance wins: software is repositioning
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scan_out_ptr <= `SMC_WORD_RESET;
    end else if (wr_take && addr == `SMC_ADDR_SHARED_POINTER) begin
      scan_out_ptr <= data_in;
    end else if (tdo_word_write) begin
      scan_out_ptr <= scan_out_ptr + `SMC_POINTER_STEP;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scan_in_ptr <= `SMC_WORD_RESET;
    end else if (wr_take && addr == `SMC_ADDR_SHARED_POINTER) begin
      scan_in_ptr <= data_in;
    end else if (tdi_word_read) begin
      scan_in_ptr <= scan_in_ptr + `SMC_POINTER_STEP;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      expected_ptr <= `SMC_WORD_RESET;
    end else if (wr_take && addr == `SMC_ADDR_SHARED_POINTER) begin
      expected_ptr <= data_in;
    end else if (expected_word_write) begin
      expected_ptr <= expected_ptr + `SMC_POINTER_STEP;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mask_ptr <= `SMC_WORD_RESET;
    end else if (wr_take && addr == `SMC_ADDR_SHARED_POINTER) begin
      mask_ptr <= data_in;
    end else if (mask_word_write) begin
      mask_ptr <= mask_ptr + `SMC_POINTER_STEP;
    end
  end

  // alignment is the writer's duty; low bits are stored as given
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      vector_ptr <= `SMC_WORD_RESET;
    end else if (wr_take && addr == `SMC_ADDR_VECTOR_POINTER) begin
      vector_ptr <= data_in;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      header_trailer_ptr <= `SMC_WORD_RESET;
    end else if (wr_take && addr == `SMC_ADDR_HT_POINTER) begin
      header_trailer_ptr <= data_in;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      macro_ptr <= `SMC_WORD_RESET;
    end else if (wr_take && addr == `SMC_ADDR_MACRO_POINTER) begin
      macro_ptr <= data_in;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sequencer_ptr <= `SMC_WORD_RESET;
    end else if (wr_take && addr == `SMC_ADDR_SEQ_POINTER) begin
      sequencer_ptr <= data_in;
    end
  end

endmodule : smc_config_pointer

/* verilog/smc_regs.svh */
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH

// register offsets on the 5-bit processor address
`define SMC_ADDR_DIVISOR 5'h05
`define SMC_ADDR_POLY_SELECT 5'h07
`define SMC_ADDR_SEED_LOW 5'h08
`define SMC_ADDR_SEED_HIGH 5'h09
`define SMC_ADDR_RESULT_LOW 5'h0A
`define SMC_ADDR_RESULT_HIGH 5'h0B
`define SMC_ADDR_SHARED_POINTER 5'h0C
`define SMC_ADDR_VECTOR_POINTER 5'h11
`define SMC_ADDR_HT_POINTER 5'h13
`define SMC_ADDR_MACRO_POINTER 5'h15
`define SMC_ADDR_SEQ_POINTER 5'h17

// field layout
`define SMC_DIV_MSB 7
`define SMC_DIV_LSB 1
`define SMC_POLY_MSB 2

// reset values
`define SMC_WORD_RESET 16'h0000
`define SMC_DIV_RESET 7'h00
`define SMC_SIG_RESET 32'h00000000
`define SMC_UNMAPPED_READ 16'h0000

// feedback taps below x^32 for each polynomial
`define SMC_POLY1_TAPS 32'h000000AF
`define SMC_POLY2_TAPS 32'h18000003
`define SMC_POLY3_TAPS 32'h000000C5

// one long word in 16-bit memory word units
`define SMC_POINTER_STEP 16'h0002

`endif

/* verilog/smc_pkg.sv */
package smc_pkg;

  typedef enum logic [1:0] {
    SMC_BUS_IDLE = 2'b01,
    SMC_BUS_HOLD = 2'b10
  } smc_bus_state_t;

  typedef enum logic [2:0] {
    SMC_POLY_NONE = 3'h0,
    SMC_POLY_ONE = 3'h1,
    SMC_POLY_TWO = 3'h2,
    SMC_POLY_THREE = 3'h3
  } smc_poly_t;

endpackage : smc_pkg

/* verilog/smc_clk_div.sv */
`timescale 1ns/1ps
`include "smc_regs.svh"

module smc_clk_div (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] divisor,
  output logic scan_clk,
  output logic scan_clk_tick
);

  logic [6:0] half_count;
  logic [6:0] half_period;
  logic at_edge;

  // the lsb of the divisor is always zero, so half the ratio is bits 7:1
  assign half_period = divisor[`SMC_DIV_MSB:`SMC_DIV_LSB];
  // >= keeps a shrinking divisor from stranding the counter past its limit
  assign at_edge = (half_count >= (half_period - 7'h01));

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      half_count <= 7'h00;
    end else if (half_period == 7'h00 || at_edge) begin
      half_count <= 7'h00;
    end else begin
      half_count <= half_count + 7'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scan_clk <= 1'b0;
    end else if (half_period == 7'h00) begin
      scan_clk <= 1'b0;
    end else if (at_edge) begin
      scan_clk <= ~scan_clk;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scan_clk_tick <= 1'b0;
    end else begin
      scan_clk_tick <= (half_period != 7'h00) && at_edge && !scan_clk;
    end
  end

endmodule : smc_clk_div

/* testbench/smc_host_model.sv */
`timescale 1ns/1ps

module smc_host_model (
  input wire logic sys_clk,
  input wire logic ack_n,
  input wire logic [15:0] data_out,
  output logic cs_n,
  output logic strobe_n,
  output logic read_not_write,
  output logic [4:0] addr,
  output logic [15:0] data_in,
  output logic hung
);
  initial begin
    cs_n = 1'b1;
    strobe_n = 1'b1;
    read_not_write = 1'b1;
    addr = 5'h00;
    data_in = 16'h0000;
    hung = 1'b0;
  end

  // a processor access; the request holds until ack is sampled low at an edge, or for 8 edges at most
  task automatic access(input logic rnw, input logic [4:0] a, input logic [15:0] d,
                        output logic [15:0] q);
    int n;
    @(posedge sys_clk);
    #1;
    cs_n = 1'b0;
    strobe_n = 1'b0;
    read_not_write = rnw;
    addr = a;
    data_in = rnw ? ~data_in : d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack_n !== 1'b0 && n < 8);
    q = data_out;
    // judge by the acknowledge itself, so a late but valid answer is not a hang
    hung = hung | (ack_n !== 1'b0);
    #1;
    cs_n = 1'b1;
    strobe_n = 1'b1;
    // a released bus must not keep showing the last word
    data_in = ~data_in;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack_n !== 1'b1 && n < 8);
    hung = hung | (ack_n !== 1'b1);
  endtask : access
endmodule : smc_host_model

/* testbench/smc_config_pointer_checker.sv */
`timescale 1ns/1ps

module smc_cp_checker (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic strobe_n,
  input wire logic read_not_write,
  input wire logic [4:0] addr,
  input wire logic [15:0] data_in,
  input wire logic data_oe,
  input wire logic ack_n,
  input wire logic scan_clk,
  input wire logic scan_clk_tick,
  input wire logic signature_start,
  input wire logic tdi_word_read,
  input wire logic [15:0] scan_out_ptr,
  input wire logic [15:0] scan_in_ptr,
  input wire logic [15:0] expected_ptr,
  input wire logic [15:0] mask_ptr,
  input wire logic [15:0] vector_ptr,
  input wire logic [31:0] signature,
  input wire logic poly_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic take;
  logic wr;
  logic clk_q;
  logic clean;
  logic [6:0] div_sh;
  logic [7:0] run;
  assign take = !cs_n && !strobe_n && ack_n;
  assign wr = take && !read_not_write;
  // a divisor rewrite spoils the half period in flight, so it is not measured
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      div_sh <= 7'h00;
      clean <= 1'b0;
    end else if (wr && addr == 5'h05) begin
      div_sh <= data_in[7:1];
      clean <= 1'b0;
    end else if (scan_clk != clk_q) begin
      clean <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      clk_q <= 1'b0;
      run <= 8'h00;
    end else begin
      clk_q <= scan_clk;
      run <= (scan_clk != clk_q) ? 8'h01 : run + 8'h01;
    end
  end
  property p_take_ack;
    take |=> !ack_n && data_oe == $past(read_not_write);
  endproperty
  a_take_ack: assert property (p_take_ack) else $error("no acknowledge after access");
  property p_release;
    (!ack_n && strobe_n) |=> ack_n && !data_oe;
  endproperty
  a_release: assert property (p_release) else $error("acknowledge not withdrawn");
  property p_shared;
    (wr && addr == 5'h0C) |=> scan_out_ptr == $past(data_in) && scan_in_ptr == $past(data_in)
      && expected_ptr == $past(data_in) && mask_ptr == $past(data_in);
  endproperty
  a_shared: assert property (p_shared) else $error("shared pointer load wrong");
  property p_vector;
    (wr && addr == 5'h11) |=> vector_ptr == $past(data_in);
  endproperty
  a_vector: assert property (p_vector) else $error("vector pointer load wrong");
  property p_in_adv;
    (tdi_word_read && !(wr && addr == 5'h0C)) |=> scan_in_ptr == $past(scan_in_ptr) + 16'h0002;
  endproperty
  a_in_adv: assert property (p_in_adv) else $error("scan in pointer not advanced");
  property p_sig_hold;
    (!poly_active && !signature_start && !wr) |=> $stable(signature);
  endproperty
  a_sig_hold: assert property (p_sig_hold) else $error("signature moved while idle");
  property p_clk_off;
    (div_sh == 7'h00) [*2] |-> !scan_clk;
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("scan clock runs at zero divisor");
  property p_period;
    (scan_clk != clk_q && clean) |-> run == {1'b0, div_sh};
  endproperty
  a_period: assert property (p_period) else $error("scan clock half period wrong");
  // the tick marks the first cycle in which the scan clock is high, never any other
  property p_tick;
    scan_clk_tick == $rose(scan_clk);
  endproperty
  a_tick: assert property (p_tick) else $error("scan clock tick out of place");
endmodule : smc_cp_checker

bind smc_config_pointer smc_cp_checker u_chk (.sys_clk, .nrst, .cs_n, .strobe_n,
  .read_not_write, .addr, .data_in, .data_oe, .ack_n, .scan_clk, .scan_clk_tick,
  .signature_start,
  .tdi_word_read, .scan_out_ptr, .scan_in_ptr, .expected_ptr, .mask_ptr, .vector_ptr,
  .signature, .poly_active);

/* testbench/smc_config_pointer_tb.sv */
`timescale 1ns/1ps
`define CMP(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end

module smc_config_pointer_tb;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic cs_n, strobe_n, read_not_write, ack_n, scan_clk, scan_data_in, poly_active, hung;
  logic [4:0] addr;
  logic [5:0] evt;
  logic [15:0] data_in, data_out, scan_out_ptr, scan_in_ptr, expected_ptr, mask_ptr;
  logic [15:0] vector_ptr, header_trailer_ptr, macro_ptr, sequencer_ptr, q;
  logic [31:0] signature, s;
  logic [4:0] regs [11] = '{5'h05, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h11, 5'h13,
                            5'h15, 5'h17};
  logic [15:0] divs [3] = '{16'h0002, 16'h0080, 16'h0007};
  int n_mismatch = 0;
  int samples_checked = 0;
  int n;

  always #20 sys_clk = ~sys_clk;

  smc_host_model host (.sys_clk(sys_clk), .ack_n(ack_n), .data_out(data_out), .cs_n(cs_n),
    .strobe_n(strobe_n), .read_not_write(read_not_write), .addr(addr), .data_in(data_in),
    .hung(hung));

  smc_config_pointer uut (.sys_clk(sys_clk), .nrst(nrst), .cs_n(cs_n), .strobe_n(strobe_n),
    .read_not_write(read_not_write), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(), .ack_n(ack_n), .scan_clk(scan_clk), .scan_clk_tick(),
    .scan_data_in(scan_data_in), .scan_in_valid(evt[1]), .signature_start(evt[0]),
    .tdi_word_read(evt[2]), .tdo_word_write(evt[3]), .expected_word_write(evt[4]),
    .mask_word_write(evt[5]), .scan_out_ptr(scan_out_ptr), .scan_in_ptr(scan_in_ptr),
    .expected_ptr(expected_ptr), .mask_ptr(mask_ptr), .vector_ptr(vector_ptr),
    .header_trailer_ptr(header_trailer_ptr), .macro_ptr(macro_ptr),
    .sequencer_ptr(sequencer_ptr), .signature(signature), .poly_active(poly_active));

  task automatic summarize();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  always @(posedge hung) begin
    n_mismatch++;
    summarize();
  end

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    host.access(1'b0, a, d, q);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    host.access(1'b1, a, 16'h0000, q);
    `CMP(q, e)
  endtask : rd

  task automatic pulse(input logic [5:0] m, input logic b);
    @(posedge sys_clk);
    #1;
    evt = m;
    scan_data_in = b;
    @(posedge sys_clk);
    #1;
    evt = 6'h00;
  endtask : pulse

  // cycles until the next sampled rise of the scan clock, 300 when none comes
  task automatic wait_rise(output int c);
    logic p;
    c = 0;
    p = scan_clk;
    do begin
      @(posedge sys_clk);
      c++;
      if (!p && scan_clk) break;
      p = scan_clk;
    end while (c < 300);
  endtask : wait_rise

  // galois step with taps taken from the polynomial terms below x^32
  function automatic logic [31:0] step(input logic [31:0] v, input logic b, input int c);
    logic [31:0] t;
    t = (c == 1) ? 32'h000000AF : (c == 2) ? 32'h18000003 : 32'h000000C5;
    return (c == 0) ? v : ({v[30:0], 1'b0} ^ ((v[31] ^ b) ? t : 32'h00000000));
  endfunction : step

  initial begin
    evt = 6'h00;
    scan_data_in = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    foreach (regs[i]) rd(regs[i], 16'h0000);
    // pairs go back to back in table order, pointers stay long-word aligned
    foreach (regs[i]) wr(regs[i], 16'h5AF4);
    foreach (regs[i]) rd(regs[i], (i == 0) ? 16'h00F4 : (i == 1) ? 16'h0004 : 16'h5AF4);
    `CMP(signature, 32'h5AF45AF4)
    `CMP({scan_out_ptr, scan_in_ptr, expected_ptr, mask_ptr}, {4{16'h5AF4}})
    `CMP({vector_ptr, header_trailer_ptr}, {2{16'h5AF4}})
    `CMP({macro_ptr, sequencer_ptr}, {2{16'h5AF4}})
    wr(5'h06, 16'hFFFF);
    rd(5'h06, 16'h0000);
    wr(5'h0C, 16'h0100);
    pulse(6'h04, 1'b0);
    pulse(6'h04, 1'b0);
    pulse(6'h28, 1'b0);
    pulse(6'h10, 1'b0);
    `CMP({scan_in_ptr, scan_out_ptr}, {16'h0104, 16'h0102})
    `CMP({expected_ptr, mask_ptr}, {16'h0102, 16'h0102})
    for (int c = 0; c < 4; c++) begin
      wr(5'h08, 16'h1357);
      wr(5'h09, 16'h2468);
      wr(5'h07, 16'(c));
      pulse(6'h01, 1'b0);
      s = 32'h24681357;
      for (int k = 0; k < 40; k++) begin
        pulse(6'h02, k[0] ^ k[2]);
        s = step(s, k[0] ^ k[2], c);
      end
      `CMP(poly_active, c != 0)
      `CMP(signature, s)
      rd(5'h0A, s[15:0]);
      rd(5'h0B, s[31:16]);
    end
    foreach (divs[i]) begin
      wr(5'h05, divs[i]);
      rd(5'h05, divs[i] & 16'h00FE);
      wait_rise(n);
      wait_rise(n);
      wait_rise(n);
      `CMP(n, int'(divs[i] & 16'h00FE))
    end
    wr(5'h05, 16'h0000);
    wait_rise(n);
    `CMP(n, 300)
    summarize();
  end
endmodule : smc_config_pointer_tb
